// ---- ips_entry_mem.sv ----
// small entry table with registered read data
module ips_entry_mem
    import ips_pkg::*;
(
    input wire logic mclk,
    ips_mem_if.mem port
);

    logic [31:0] mem_reg [ENTRY_COUNT];

    // write port, no reset: contents are always refilled before use
    always_ff @(posedge mclk)
    begin
        if (port.we)
        begin
            mem_reg[port.waddr] <= port.wdata;
        end
    end

    // read data come out of a register, one cycle after the address
    always_ff @(posedge mclk)
    begin
        port.rdata <= mem_reg[port.raddr];
    end

endmodule

// ---- ips_flash_model.sv ----
// partner model: pointer-block flash and the update host that edits it
module ips_flash_model
    import ips_pkg::*;
#(
    parameter logic [31:0] FIRST_IMAGE = 32'h002f4000
)
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic flash_rd_req,
    input wire logic [31:0] flash_rd_addr,
    output logic flash_rd_valid,
    output logic [31:0] flash_rd_data,
    output logic flash_rd_err
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [31:0] mem [2][4];
    logic err_copy [2];
    int lat;
    int cnt;
    logic host_owns;
    logic [31:0] erased_img;

    // both copies start with one image in entry 0, the rest unwritten
    initial
    begin
        lat = 0;
        host_owns = 1'b0;
        erased_img = ENTRY_BLANK;
        err_copy[0] = 1'b0;
        err_copy[1] = 1'b0;
        for (int c = 0; c < 2; c++)
            for (int i = 0; i < 4; i++)
                mem[c][i] = (i == 0) ? FIRST_IMAGE : ENTRY_BLANK;
    end

    // answer after lat idle cycles; lines churn so nothing stale looks valid
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            flash_rd_valid <= 1'b0;
            flash_rd_data <= 32'h5a5a5a5a;
            flash_rd_err <= 1'b0;
            cnt <= 0;
        end
        else if (flash_rd_req && !flash_rd_valid && cnt >= lat)
        begin
            flash_rd_valid <= 1'b1;
            flash_rd_data <= mem[flash_rd_addr[15]][flash_rd_addr[4:3]];
            flash_rd_err <= err_copy[flash_rd_addr[15]];
            cnt <= 0;
        end
        else
        begin
            flash_rd_valid <= 1'b0;
            flash_rd_data <= ~flash_rd_data;
            flash_rd_err <= ~flash_rd_err;
            cnt <= (flash_rd_req && !flash_rd_valid) ? cnt + 1 : 0;
        end
    end

    task automatic write_word(input int c, input int i, input logic [31:0] v);
        if (host_owns)
            mem[c][i] = v;
    endtask

    // host adds an image pointer; ok is low if refused or not read back
    task automatic host_add(input int i, input logic [31:0] img, output logic ok);
        host_owns = 1'b1;
        ok = (mem[0][i] === ENTRY_BLANK) && (mem[1][i] === ENTRY_BLANK);
        if (ok)
        begin
            write_word(0, i, img);
            write_word(1, i, img);
        end
        ok = ok && (mem[0][i] === img) && (mem[1][i] === img);
        host_owns = 1'b0;
    endtask

    // host records the image a pointer names as erased, then removes the pointer
    task automatic host_remove(input int i);
        host_owns = 1'b1;
        erased_img = mem[0][i];
        write_word(0, i, ENTRY_REMOVED);
        write_word(1, i, ENTRY_REMOVED);
        host_owns = 1'b0;
    endtask

    // deliberate fault: one copy edited alone, breaking the mirror
    task automatic corrupt(input int c, input int i, input logic [31:0] v);
        mem[c][i] = v;
    endtask
endmodule

// ---- ips_loader.sv ----
// top: picks the application image to boot from the pointer entries
// Operation
// - the loader scans pointer entries from the last back to the first.
// - entries sit at 0x20 plus eight per entry and a higher offset wins.
// - an all-zero entry is removed and is skipped for the next lower one.
// - a reconfiguration request or power cycle boots the top-priority image.
// - after booting, the status shows the start address of the running image.
// - an older image stays in the list as a fallback below a newer one.
module ips_loader
    import ips_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic reconfig_request_n,
    output logic flash_rd_req,
    output logic [31:0] flash_rd_addr,
    input wire logic flash_rd_valid,
    input wire logic [31:0] flash_rd_data,
    input wire logic flash_rd_err,
    output logic boot_start,
    output logic [31:0] boot_addr,
    output logic [31:0] current_image_addr,
    output logic factory_boot,
    output logic used_copy1,
    output logic loader_busy
);
    import ips_pkg::*;

    ips_state_e state_reg;
    logic [IDX_W-1:0] idx_reg;
    logic req_n_prev_reg;
    logic pending_reg;
    logic copy0_bad_reg;
    logic copy1_bad_reg;
    logic mismatch_reg;
    logic flash_req_reg;
    logic [31:0] flash_addr_reg;
    logic boot_start_reg;
    logic [31:0] boot_addr_reg;
    logic [31:0] current_reg;
    logic factory_reg;
    logic busy_reg;
    logic req_event;
    logic flash_done;
    logic entry_ok;
    logic copy1_take;

    ips_mem_if mem_bus ();

    ips_entry_mem u_mem
    (
        .mclk (mclk),
        .port (mem_bus.mem)
    );

    // ****************************************************************
    // trigger and flash answer decode
    // ****************************************************************
    assign req_event = req_n_prev_reg & ~reconfig_request_n;
    assign flash_done = flash_req_reg & flash_rd_valid;
    // both copies unreadable leaves nothing trustworthy to scan
    assign entry_ok = ips_entry_live(mem_bus.rdata) & ~(copy0_bad_reg & copy1_bad_reg);
    assign copy1_take = flash_done & ~flash_rd_err
                        & (copy0_bad_reg | mismatch_reg | (flash_rd_data != mem_bus.rdata));

    // ****************************************************************
    // entry table writes
    // ****************************************************************
    // copy1 words replace copy0 only when copy0 cannot be trusted
    assign mem_bus.raddr = idx_reg;
    assign mem_bus.waddr = idx_reg;
    assign mem_bus.wdata = flash_rd_data;
    assign mem_bus.we = (state_reg == ST_RD0) ? (flash_done & ~flash_rd_err)
                      : (state_reg == ST_RD1) ? copy1_take : 1'b0;

    // edge detector on the request pin, pin taken as synchronous
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            req_n_prev_reg <= 1'b1;
        end
        else
        begin
            req_n_prev_reg <= reconfig_request_n;
        end
    end

    // pending boot; set at power-on and on a request, set beats clear
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            pending_reg <= BOOT_PENDING_RESET;
        end
        else if (req_event)
        begin
            pending_reg <= 1'b1;
        end
        else if (state_reg == ST_IDLE)
        begin
            pending_reg <= 1'b0;
        end
    end

    // copy health flags, cleared at the start of each load
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            copy0_bad_reg <= 1'b0;
            copy1_bad_reg <= 1'b0;
            mismatch_reg <= 1'b0;
        end
        else if (state_reg == ST_IDLE && pending_reg)
        begin
            copy0_bad_reg <= 1'b0;
            copy1_bad_reg <= 1'b0;
            mismatch_reg <= 1'b0;
        end
        else if (state_reg == ST_RD0 && flash_done && flash_rd_err)
        begin
            copy0_bad_reg <= 1'b1;
        end
        else if (state_reg == ST_RD1 && flash_done)
        begin
            if (flash_rd_err)
            begin
                copy1_bad_reg <= 1'b1;
            end
            else if (flash_rd_data != mem_bus.rdata)
            begin
                mismatch_reg <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // sequencer: read copy0, read copy1, scan, boot
    // ****************************************************************
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg <= ST_IDLE;
            idx_reg <= IDX_FIRST;
            flash_req_reg <= 1'b0;
            flash_addr_reg <= ADDR_RESET;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                begin
                    if (pending_reg)
                    begin
                        state_reg <= ST_RD0;
                        idx_reg <= IDX_FIRST;
                        flash_req_reg <= 1'b1;
                        flash_addr_reg <= ips_entry_addr(PB_COPY0_BASE, IDX_FIRST);
                    end
                end
                ST_RD0:
                begin
                    if (flash_done)
                    begin
                        if (idx_reg == IDX_LAST)
                        begin
                            state_reg <= ST_RD1;
                            idx_reg <= IDX_FIRST;
                            flash_addr_reg <= ips_entry_addr(PB_COPY1_BASE, IDX_FIRST);
                        end
                        else
                        begin
                            idx_reg <= idx_reg + 2'h1;
                            flash_addr_reg <= ips_entry_addr(PB_COPY0_BASE, idx_reg + 2'h1);
                        end
                    end
                end
                ST_RD1:
                begin
                    if (flash_done)
                    begin
                        if (idx_reg == IDX_LAST)
                        begin
                            // scan starts at the last entry
                            state_reg <= ST_SCAN_RD;
                            flash_req_reg <= 1'b0;
                        end
                        else
                        begin
                            idx_reg <= idx_reg + 2'h1;
                            flash_addr_reg <= ips_entry_addr(PB_COPY1_BASE, idx_reg + 2'h1);
                        end
                    end
                end
                ST_SCAN_RD:
                begin
                    // table read data are ready one cycle later
                    state_reg <= ST_SCAN_CHK;
                end
                ST_SCAN_CHK:
                begin
                    if (entry_ok || idx_reg == IDX_FIRST)
                    begin
                        state_reg <= ST_IDLE;
                    end
                    else
                    begin
                        idx_reg <= idx_reg - 2'h1;
                        state_reg <= ST_SCAN_RD;
                    end
                end
                default:
                begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // boot outputs and status
    // ****************************************************************
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            boot_start_reg <= 1'b0;
            boot_addr_reg <= ADDR_RESET;
            current_reg <= ADDR_RESET;
            factory_reg <= 1'b0;
        end
        else if (state_reg == ST_SCAN_CHK && entry_ok)
        begin
            boot_start_reg <= 1'b1;
            boot_addr_reg <= mem_bus.rdata;
            current_reg <= mem_bus.rdata;
            factory_reg <= 1'b0;
        end
        else if (state_reg == ST_SCAN_CHK && idx_reg == IDX_FIRST)
        begin
            boot_start_reg <= 1'b1;
            boot_addr_reg <= FACTORY_IMAGE_ADDR;
            current_reg <= FACTORY_IMAGE_ADDR;
            factory_reg <= 1'b1;
        end
        else
        begin
            boot_start_reg <= 1'b0;
        end
    end

    // busy and copy selection status
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            busy_reg <= 1'b0;
            used_copy1 <= 1'b0;
        end
        else
        begin
            busy_reg <= (state_reg != ST_IDLE) || pending_reg;
            used_copy1 <= (copy0_bad_reg | mismatch_reg) & ~copy1_bad_reg;
        end
    end

    assign flash_rd_req = flash_req_reg;
    assign flash_rd_addr = flash_addr_reg;
    assign boot_start = boot_start_reg;
    assign boot_addr = boot_addr_reg;
    assign current_image_addr = current_reg;
    assign factory_boot = factory_reg;
    assign loader_busy = busy_reg;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    property p_scan_from_last;
        (state_reg == ST_RD1 && flash_done && idx_reg == IDX_LAST)
        |=> (state_reg == ST_SCAN_RD && idx_reg == IDX_LAST);
    endproperty
    a_scan_from_last: assert property (p_scan_from_last)
        else $error("scan did not start at the last entry");

    property p_entry_offset;
        (state_reg == ST_RD0 && flash_req_reg)
        |-> (flash_addr_reg == PB_COPY0_BASE + 32'h20 + 32'h8 * {30'h0, idx_reg});
    endproperty
    a_entry_offset: assert property (p_entry_offset)
        else $error("pointer entry address wrong");

    property p_skip_removed;
        (state_reg == ST_SCAN_CHK && mem_bus.rdata == 32'h0 && idx_reg != IDX_FIRST)
        |=> (state_reg == ST_SCAN_RD && idx_reg == $past(idx_reg) - 2'h1 && !boot_start);
    endproperty
    a_skip_removed: assert property (p_skip_removed)
        else $error("removed entry not skipped");

    property p_request_boots;
        (state_reg == ST_IDLE && req_event)
        |=> ##[1:80] boot_start;
    endproperty
    a_request_boots: assert property (p_request_boots)
        else $error("request did not lead to a boot");

    property p_status_matches;
        boot_start |-> (current_image_addr == boot_addr);
    endproperty
    a_status_matches: assert property (p_status_matches)
        else $error("status differs from booted image");

    property p_boot_live_entry;
        (state_reg == ST_SCAN_CHK && entry_ok)
        |=> boot_start && boot_addr == $past(mem_bus.rdata) && !factory_boot;
    endproperty
    a_boot_live_entry: assert property (p_boot_live_entry)
        else $error("live entry not booted");

    property p_copy1_override;
        (state_reg == ST_RD1 && copy0_bad_reg && flash_done && !flash_rd_err)
        |-> mem_bus.we;
    endproperty
    a_copy1_override: assert property (p_copy1_override)
        else $error("copy1 word not taken over bad copy0");

    property p_factory;
        (state_reg == ST_SCAN_CHK && !entry_ok && idx_reg == IDX_FIRST)
        |=> boot_start && factory_boot && boot_addr == 32'h00110000;
    endproperty
    a_factory: assert property (p_factory)
        else $error("factory image not booted");

endmodule

// ---- ips_mem_if.sv ----
// interface: entry table port between the loader and its memory
interface ips_mem_if;
    import ips_pkg::*;
    logic we;
    logic [IDX_W-1:0] waddr;
    logic [31:0] wdata;
    logic [IDX_W-1:0] raddr;
    logic [31:0] rdata;

    modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// ---- ips_pkg.sv ----
// package: constants and types for the image pointer selector
package ips_pkg;

    // ****************************************************************
    // flash map of the pointer blocks and images
    // ****************************************************************
    localparam logic [31:0] PB_COPY0_BASE = 32'h002e4000;
    localparam logic [31:0] PB_COPY1_BASE = 32'h002ec000;
    localparam logic [31:0] FACTORY_IMAGE_ADDR = 32'h00110000;
    localparam logic [31:0] ENTRY_FIRST_OFFSET = 32'h00000020;
    localparam logic [31:0] ENTRY_STRIDE = 32'h00000008;

    // ****************************************************************
    // entry table shape and special entry values
    // ****************************************************************
    localparam int ENTRY_COUNT = 4;
    localparam int IDX_W = 2;
    localparam logic [IDX_W-1:0] IDX_FIRST = 2'h0;
    localparam logic [IDX_W-1:0] IDX_LAST = 2'h3;
    localparam logic [31:0] ENTRY_REMOVED = 32'h00000000;
    localparam logic [31:0] ENTRY_BLANK = 32'hffffffff;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic BOOT_PENDING_RESET = 1'b1;
    localparam logic [31:0] ADDR_RESET = 32'h00000000;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b000,
        ST_RD0 = 3'b001,
        ST_RD1 = 3'b010,
        ST_SCAN_RD = 3'b011,
        ST_SCAN_CHK = 3'b100
    } ips_state_e;

    // flash byte address of one pointer entry
    function automatic logic [31:0] ips_entry_addr(input logic [31:0] base,
                                                    input logic [IDX_W-1:0] idx);
        ips_entry_addr = base + ENTRY_FIRST_OFFSET + ENTRY_STRIDE * {30'h0, idx};
    endfunction

    // entry that points at a bootable image
    function automatic logic ips_entry_live(input logic [31:0] value);
        ips_entry_live = (value != ENTRY_REMOVED) && (value != ENTRY_BLANK);
    endfunction

endpackage

// ---- tb_top.sv ----
// testbench: boots the image pointer selector against the flash model
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import ips_pkg::*;

    localparam logic [31:0] OLD_IMAGE = 32'h002f4000;
    localparam logic [31:0] NEW_IMAGE = 32'h03ff0000;
    logic mclk;
    logic rstn;
    logic reconfig_request_n;
    logic flash_rd_req;
    logic [31:0] flash_rd_addr;
    logic flash_rd_valid;
    logic [31:0] flash_rd_data;
    logic flash_rd_err;
    logic boot_start;
    logic [31:0] boot_addr;
    logic [31:0] current_image_addr;
    logic factory_boot;
    logic used_copy1;
    logic loader_busy;
    logic ok;
    int n_fail = 0;
    int n_tests = 0;

    ips_loader dut (
        .mclk(mclk),
        .rstn(rstn),
        .reconfig_request_n(reconfig_request_n),
        .flash_rd_req(flash_rd_req),
        .flash_rd_addr(flash_rd_addr),
        .flash_rd_valid(flash_rd_valid),
        .flash_rd_data(flash_rd_data),
        .flash_rd_err(flash_rd_err),
        .boot_start(boot_start),
        .boot_addr(boot_addr),
        .current_image_addr(current_image_addr),
        .factory_boot(factory_boot),
        .used_copy1(used_copy1),
        .loader_busy(loader_busy)
    );

    ips_flash_model #(.FIRST_IMAGE(OLD_IMAGE)) flash (
        .mclk(mclk),
        .rstn(rstn),
        .flash_rd_req(flash_rd_req),
        .flash_rd_addr(flash_rd_addr),
        .flash_rd_valid(flash_rd_valid),
        .flash_rd_data(flash_rd_data),
        .flash_rd_err(flash_rd_err)
    );

    // 10 MHz clock
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // ****************************************************************
    // checking helpers
    // ****************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t ns: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // nth read of a load: copy0 entries, then copy1, lowest offset first
    function automatic logic [31:0] read_addr(input int n);
        read_addr = ((n < 4) ? PB_COPY0_BASE : PB_COPY1_BASE) + ENTRY_FIRST_OFFSET
            + ENTRY_STRIDE * 32'(n % 4);
    endfunction

    // one load: reads sampled at negedge are the ones taken at the next edge
    task automatic run_boot(input logic pin, input logic [31:0] img, input int idx,
                            input logic c1);
        int n_ans;
        int t_ans;
        int t_boot;
        n_ans = 0;
        t_ans = 0;
        t_boot = -1;
        if (pin)
        begin
            @(posedge mclk) reconfig_request_n <= 1'b0;
            @(posedge mclk) reconfig_request_n <= 1'b1;
        end
        for (int c = 0; c < 400 && t_boot < 0; c++)
        begin
            @(negedge mclk);
            if (flash_rd_req === 1'b1 && flash_rd_valid === 1'b1)
            begin
                chk(flash_rd_addr, read_addr(n_ans), "read address");
                n_ans++;
                t_ans = c;
            end
            if (boot_start === 1'b1)
                t_boot = c;
        end
        if (t_boot < 0)
        begin
            n_fail++;
            stop_test();
        end
        chk(32'(n_ans), 32'h8, "reads per load");
        if (idx >= 0)
            chk(32'(t_boot - t_ans), 32'(3 + 2 * (3 - idx)), "scan time");
        chk(boot_addr, img, "boot address");
        chk(current_image_addr, img, "running image");
        chk({31'h0, factory_boot}, {31'h0, idx < 0}, "factory flag");
        chk({31'h0, used_copy1}, {31'h0, c1}, "copy choice");
        chk({31'h0, loader_busy}, 32'h1, "busy at boot");
        @(negedge mclk);
        chk({31'h0, boot_start}, 32'h0, "boot pulse width");
        chk({31'h0, loader_busy}, 32'h0, "busy after boot");
        chk({31'h0, flash_rd_req}, 32'h0, "flash idle after load");
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic s_power_up();
        repeat (10) @(posedge mclk);
        chk({31'h0, flash_rd_req}, 32'h0, "request in reset");
        chk(boot_addr, ADDR_RESET, "boot address in reset");
        rstn <= 1'b1;
        run_boot(1'b0, OLD_IMAGE, 0, 1'b0);
    endtask

    // newer entry wins over the older one; slow flash answers
    task automatic s_add();
        flash.lat = 3;
        flash.host_add(1, NEW_IMAGE, ok);
        chk({31'h0, ok}, 32'h1, "host add");
        flash.host_add(1, OLD_IMAGE, ok);
        chk({31'h0, ok}, 32'h0, "write over used entry");
        run_boot(1'b1, NEW_IMAGE, 1, 1'b0);
        flash.lat = 0;
    endtask

    task automatic s_remove();
        flash.host_remove(1);
        chk(flash.erased_img, NEW_IMAGE, "erased image");
        run_boot(1'b1, OLD_IMAGE, 0, 1'b0);
    endtask

    // mismatched copies, copy0 read error, copy1 read error
    task automatic s_copy_fault();
        flash.corrupt(0, 2, 32'h05550000);
        run_boot(1'b1, OLD_IMAGE, 0, 1'b1);
        flash.corrupt(0, 2, ENTRY_BLANK);
        flash.err_copy[0] = 1'b1;
        run_boot(1'b1, OLD_IMAGE, 0, 1'b1);
        flash.err_copy[0] = 1'b0;
        flash.err_copy[1] = 1'b1;
        run_boot(1'b1, OLD_IMAGE, 0, 1'b0);
        flash.err_copy[1] = 1'b0;
    endtask

    task automatic s_factory();
        flash.host_remove(0);
        run_boot(1'b1, FACTORY_IMAGE_ADDR, -1, 1'b0);
    endtask

    initial
    begin
        rstn = 1'b0;
        reconfig_request_n = 1'b1;
        s_power_up();
        s_add();
        s_remove();
        s_copy_fault();
        s_factory();
        stop_test();
    end
endmodule
